// ==== rtl/mrg_gate.sv ====
// Register access gate between protocol front ends and the sensor tables.
// Assumes parsed requests from each interface's framing layer and a
// backend that answers a table lookup one cycle after the lookup strobe.
//
// Overview of operation
// R1 - One client connection per protocol interface.
// R2 - Reads are served with or without parametrisation.
// R3 - Writes take effect only under held parametrisation.
// R4 - Parametrisation held by one interface at most.
// R5 - Process interfaces write only mode, laser, setup.
// R6 - Read codes 02, 04, 03 served.
// R7 - Write codes 06 and 16 served.
// R8 - Each function-code table decoded on its own.
// R9 - Registers are 16 bits, wide values span several.
// R10 - Client accesses whole multi-register values only.
// R11 - Low word sits at the lower address.
// R12 - Write-only register reads back as all ones.
// R13 - Client obtains parametrisation before loading or laser.
// R14 - Frame addresses count from zero.
// R15 - Refused write answered with an exception.
`timescale 1ns/1ns
`include "mrg_defines.svh"

module mrg_gate
  import mrg_pkg::*;
#(
  parameter int N_IF = 3,
  parameter int IFW = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [N_IF-1:0] conn_open,
  input wire logic [N_IF-1:0] conn_close,
  output logic [N_IF-1:0] conn_active,
  output logic [N_IF-1:0] conn_refused,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [IFW-1:0] req_if,
  input wire logic [7:0] req_fc,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic wdat_valid,
  output logic wdat_ready,
  input wire logic [15:0] wdat_data,
  output logic rsp_valid,
  output logic rsp_last,
  output logic rsp_exc,
  output logic [7:0] rsp_code,
  output logic [15:0] rsp_data,
  output logic be_rd,
  output mrg_table_e be_table,
  output logic [15:0] be_addr,
  input wire logic [1:0] be_words,
  input wire logic be_first,
  input wire logic be_wo,
  input wire logic [31:0] be_rdata,
  output logic be_wr,
  output logic [31:0] be_wdata,
  output logic pm_held,
  output logic [IFW-1:0] pm_owner
);

  // ----------------------------------------------------------------------
  // Connection slots
  // ----------------------------------------------------------------------
  // Each interface has its own slot; they never interact.
  for (genvar i = 0; i < N_IF; i++) begin : g_slot
    mrg_conn_slot u_slot (
      .clk_sys(clk_sys),
      .reset(reset),
      .open_req(conn_open[i]),
      .close_req(conn_close[i]),
      .active(conn_active[i]),
      .refused(conn_refused[i])
    );
  end

  // ----------------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------------
  mrg_state_e state_q, state_d; // Sequencer state.
  logic [IFW-1:0] if_q, if_d; // Interface that owns the request.
  logic [7:0] fc_q, fc_d; // Function code of the request.
  logic [15:0] addr_q, addr_d; // Current register address.
  logic [15:0] left_q, left_d; // Registers still to transfer.
  logic [1:0] w_q, w_d; // Width of the current item in words.
  logic wo_q, wo_d; // Current item is write-only.
  logic [31:0] data_q, data_d; // Item value, low word in bits 15:0.
  logic pm_held_q; // Parametrisation mode is held.
  logic [IFW-1:0] pm_owner_q; // Interface that holds it.
  logic rsp_valid_q, rsp_last_q, rsp_exc_q;
  logic [7:0] rsp_code_q;
  logic [15:0] rsp_data_q;

  // Combinational request decode and sequencer outputs.
  logic rq_rd, rq_wr, rq_conn, rq_owner;
  logic [15:0] rq_cnt, rq_max;
  logic is_rd, is_wr, internal, allowed, owner_ok;
  logic [1:0] u_words;
  logic [15:0] w_ext;
  mrg_table_e tbl;
  logic emit, emit_last, emit_exc;
  logic [7:0] emit_code;
  logic [15:0] emit_data;
  logic pm_take, pm_drop;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Decode of the incoming request, used only while idle.
  always_comb begin
    rq_rd = (req_fc == `MRG_FC_RD_DI) || (req_fc == `MRG_FC_RD_HR) ||
            (req_fc == `MRG_FC_RD_IR); // R6
    rq_wr = (req_fc == `MRG_FC_WR_ONE) ||
            (req_fc == `MRG_FC_WR_MANY); // R7
    rq_cnt = (req_fc == `MRG_FC_WR_ONE) ? `MRG_ONE_WORD : req_count;
    rq_max = rq_rd ? `MRG_RD_MAX : `MRG_WR_MAX;
    rq_conn = (req_if < IFW'(N_IF)) && conn_active[req_if]; // R1
    rq_owner = pm_held_q && (pm_owner_q == req_if);
  end

  // Decode of the request in progress. Each read code picks its own table and writes use the HR table, so
  // one address means unrelated things in different tables.
  always_comb begin
    is_rd = (fc_q == `MRG_FC_RD_DI) || (fc_q == `MRG_FC_RD_HR) ||
            (fc_q == `MRG_FC_RD_IR);
    is_wr = !is_rd;
    if (fc_q == `MRG_FC_RD_DI) begin
      tbl = MRG_TBL_DI; // R8
    end else if (fc_q == `MRG_FC_RD_IR) begin
      tbl = MRG_TBL_IR; // R8
    end else begin
      tbl = MRG_TBL_HR; // R8
    end
    // The mode request and exit registers live in the gate itself.
    internal = (tbl == MRG_TBL_HR) && ((addr_q == `MRG_HR_REQ_PM) ||
               (addr_q == `MRG_HR_EXIT_PM));
    // Only the web path configures freely; the rest are narrowed.
    allowed = (if_q == IFW'(`MRG_WEB_IF)) || internal ||
              (addr_q == `MRG_HR_LASER) || (addr_q == `MRG_HR_SETUP); // R5
    owner_ok = pm_held_q && (pm_owner_q == if_q);
    u_words = (internal || be_words != 2'd2) ? 2'd1 : 2'd2; // R9
    w_ext = {14'h0000, w_q};
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Walks one request register by register. Words of a read are sent as
  // they are found; a later exception ends the answer, so the framing
  // layer must hold words until the last one arrives.
  always_comb begin
    state_d = state_q;
    if_d = if_q;
    fc_d = fc_q;
    addr_d = addr_q;
    left_d = left_q;
    w_d = w_q;
    wo_d = wo_q;
    data_d = data_q;
    emit = 1'b0;
    emit_last = 1'b0;
    emit_exc = 1'b0;
    emit_code = `MRG_RST_CODE;
    emit_data = `MRG_RST_WORD;
    pm_take = 1'b0;
    pm_drop = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          if_d = req_if;
          fc_d = req_fc;
          addr_d = req_addr; // R14
          left_d = rq_cnt;
          emit = 1'b1;
          emit_last = 1'b1;
          emit_exc = 1'b1;
          if (!rq_conn) begin
            emit_code = `MRG_EXC_NO_CONN;
          end else if (!(rq_rd || rq_wr)) begin
            emit_code = `MRG_EXC_ILL_FUNC;
          end else if (rq_cnt == 16'h0000 || rq_cnt > rq_max) begin
            emit_code = `MRG_EXC_ILL_VALUE;
          end else if (rq_wr && !rq_owner &&
                       req_addr != `MRG_HR_REQ_PM) begin
            emit_code = `MRG_EXC_NO_PM; // R15
          end else begin
            // Reads pass regardless of the mode.
            emit = 1'b0; // R2
            emit_last = 1'b0;
            emit_exc = 1'b0;
            state_d = ST_LOOK;
          end
        end
      end
      ST_LOOK: begin
        state_d = ST_USE;
      end
      ST_USE: begin
        w_d = u_words;
        wo_d = internal || be_wo;
        data_d = be_rdata;
        if (!(internal || be_first) || {14'h0000, u_words} > left_q) begin
          // A partial wide value is refused as a bad address.
          emit = 1'b1; // R10
          emit_last = 1'b1;
          emit_exc = 1'b1;
          emit_code = `MRG_EXC_ILL_ADDR;
          state_d = ST_IDLE;
        end else if (is_wr && !allowed) begin
          emit = 1'b1; // R5
          emit_last = 1'b1;
          emit_exc = 1'b1;
          emit_code = `MRG_EXC_ILL_ADDR;
          state_d = ST_IDLE;
        end else if (is_rd) begin
          // Low word first, at the lower address.
          emit = 1'b1; // R11
          emit_data = (internal || be_wo) ? `MRG_WO_VALUE :
                      be_rdata[15:0]; // R12
          if (u_words == 2'd2) begin
            state_d = ST_HI;
          end else begin
            addr_d = addr_q + 16'h0001;
            left_d = left_q - 16'h0001;
            emit_last = (left_q == 16'h0001);
            state_d = emit_last ? ST_IDLE : ST_LOOK;
          end
        end else begin
          state_d = ST_WLO;
        end
      end
      ST_HI: begin
        emit = 1'b1; // R11
        emit_data = wo_q ? `MRG_WO_VALUE : data_q[31:16]; // R12
        emit_last = (left_q == 16'h0002);
        addr_d = addr_q + 16'h0002;
        left_d = left_q - 16'h0002;
        state_d = emit_last ? ST_IDLE : ST_LOOK;
      end
      ST_WLO: begin
        if (wdat_valid) begin
          data_d = {16'h0000, wdat_data}; // R11
          state_d = (w_q == 2'd2) ? ST_WHI : ST_COMMIT;
        end
      end
      ST_WHI: begin
        if (wdat_valid) begin
          data_d = {wdat_data, data_q[15:0]}; // R11
          state_d = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        addr_d = addr_q + w_ext;
        left_d = left_q - w_ext;
        emit_last = (left_q == w_ext);
        emit = emit_last;
        state_d = emit_last ? ST_IDLE : ST_LOOK;
        if (internal && addr_q == `MRG_HR_REQ_PM && pm_held_q &&
            pm_owner_q != if_q) begin
          // The mode is taken by another interface.
          emit = 1'b1; // R4
          emit_last = 1'b1;
          emit_exc = 1'b1;
          emit_code = `MRG_EXC_BUSY;
          state_d = ST_IDLE;
        end else if (!internal && !owner_ok) begin
          // The mode was left part way through the request.
          emit = 1'b1; // R15
          emit_last = 1'b1;
          emit_exc = 1'b1;
          emit_code = `MRG_EXC_NO_PM;
          state_d = ST_IDLE;
        end else begin
          pm_take = internal && addr_q == `MRG_HR_REQ_PM;
          pm_drop = internal && addr_q == `MRG_HR_EXIT_PM && owner_ok;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request datapath.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      if_q <= '0;
      fc_q <= `MRG_RST_CODE;
      addr_q <= `MRG_RST_WORD;
      left_q <= `MRG_RST_WORD;
      w_q <= 2'd1;
      wo_q <= 1'b0;
      data_q <= `MRG_RST_DATA;
    end else begin
      if_q <= if_d;
      fc_q <= fc_d;
      addr_q <= addr_d;
      left_q <= left_d;
      w_q <= w_d;
      wo_q <= wo_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------------
  // Parametrisation mode
  // ----------------------------------------------------------------------
  // Granting wins over a release in the same cycle. An owner that loses
  // its connection gives the mode up, otherwise it would be stuck.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pm_held_q <= 1'b0;
      pm_owner_q <= '0;
    end else if (pm_take) begin
      pm_held_q <= 1'b1; // R4
      pm_owner_q <= if_q;
    end else if (pm_drop || (pm_held_q && conn_close[pm_owner_q])) begin
      pm_held_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Response and backend outputs
  // ----------------------------------------------------------------------
  // Answers are registered; valid is a one-cycle pulse per word.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      rsp_exc_q <= 1'b0;
      rsp_code_q <= `MRG_RST_CODE;
      rsp_data_q <= `MRG_RST_WORD;
    end else begin
      rsp_valid_q <= emit;
      rsp_last_q <= emit && emit_last;
      rsp_exc_q <= emit && emit_exc;
      rsp_code_q <= emit_code;
      rsp_data_q <= emit_data;
    end
  end

  assign req_ready = (state_q == ST_IDLE);
  assign wdat_ready = (state_q == ST_WLO) || (state_q == ST_WHI);
  assign be_rd = (state_q == ST_LOOK);
  assign be_table = tbl;
  assign be_addr = addr_q;
  // Forwarded writes happen only for the mode holder.
  assign be_wr = (state_q == ST_COMMIT) && !internal && owner_ok; // R3
  assign be_wdata = data_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_last = rsp_last_q;
  assign rsp_exc = rsp_exc_q;
  assign rsp_code = rsp_code_q;
  assign rsp_data = rsp_data_q;
  assign pm_held = pm_held_q;
  assign pm_owner = pm_owner_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_accept;
    state_q == ST_IDLE && req_valid && rq_conn;
  endsequence

  property p_one_conn;
    conn_open[0] && conn_active[0] && !conn_close[0] |=>
      conn_refused[0] && conn_active[0];
  endproperty
  a_one_conn: assert property (p_one_conn) // R1
    else $error("second client not refused");

  property p_read_free;
    s_accept ##0 (rq_rd && rq_cnt == 16'h0001) |=>
      state_q == ST_LOOK ##1 state_q == ST_USE;
  endproperty
  a_read_free: assert property (p_read_free) // R2
    else $error("read not served");

  property p_wr_owner;
    be_wr |-> pm_held_q && pm_owner_q == if_q && fc_q != `MRG_FC_RD_HR;
  endproperty
  a_wr_owner: assert property (p_wr_owner) // R3
    else $error("write without mode");

  property p_one_owner;
    pm_held_q && $past(pm_held_q) |-> pm_owner_q == $past(pm_owner_q);
  endproperty
  a_one_owner: assert property (p_one_owner) // R4
    else $error("mode moved while held");

  property p_limited;
    state_q == ST_USE && is_wr && !allowed && !wo_d && be_first |=>
      rsp_exc_q && rsp_code_q == `MRG_EXC_ILL_ADDR;
  endproperty
  a_limited: assert property (p_limited) // R5
    else $error("restricted write not refused");

  property p_table;
    be_rd && fc_q == `MRG_FC_RD_IR |-> be_table == MRG_TBL_IR;
  endproperty
  a_table: assert property (p_table) // R8
    else $error("wrong table selected");

  property p_partial;
    state_q == ST_USE && !internal && be_first && be_words == 2'd2 &&
      left_q == 16'h0001 |=> rsp_exc_q && rsp_code_q == `MRG_EXC_ILL_ADDR;
  endproperty
  a_partial: assert property (p_partial) // R10
    else $error("partial wide access not refused");

  sequence s_two_words;
    rsp_valid_q && rsp_data_q == data_q[15:0] ##1
      rsp_valid_q && rsp_data_q == $past(data_q[31:16]);
  endsequence

  property p_low_first;
    state_q == ST_HI && !wo_q |-> s_two_words;
  endproperty
  a_low_first: assert property (p_low_first) // R11
    else $error("word order wrong");

  property p_wo_read;
    state_q == ST_USE && is_rd && be_wo && be_first && left_q != 16'h0000
      |=> rsp_data_q == `MRG_WO_VALUE;
  endproperty
  a_wo_read: assert property (p_wo_read) // R12
    else $error("write-only read not all ones");

  property p_zero_based;
    s_accept ##0 state_d == ST_LOOK |=> ##1 be_addr == $past(req_addr, 2);
  endproperty
  a_zero_based: assert property (p_zero_based) // R14
    else $error("address shifted");

  property p_refuse;
    s_accept ##0 (req_fc == `MRG_FC_WR_ONE && !rq_owner &&
      req_addr != `MRG_HR_REQ_PM) |=> rsp_valid_q && rsp_exc_q &&
      rsp_last_q && rsp_code_q == `MRG_EXC_NO_PM;
  endproperty
  a_refuse: assert property (p_refuse) // R15
    else $error("refused write not answered");

endmodule

// ==== rtl/mrg_defines.svh ====
// Constants of the register access gate: function codes, table addresses,
// limits, exception codes and reset values.
// Assumes inclusion by bare name from the gate's design files.
`ifndef MRG_DEFINES_SVH
`define MRG_DEFINES_SVH

// ----------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------
`define MRG_FC_RD_DI 8'h02
`define MRG_FC_RD_HR 8'h03
`define MRG_FC_RD_IR 8'h04
`define MRG_FC_WR_ONE 8'h06
`define MRG_FC_WR_MANY 8'h10

// ----------------------------------------------------------------------
// Quantity limits per request, in registers
// ----------------------------------------------------------------------
`define MRG_RD_MAX 16'h007d
`define MRG_WR_MAX 16'h007b
`define MRG_ONE_WORD 16'h0001

// ----------------------------------------------------------------------
// Holding register addresses, zero based
// ----------------------------------------------------------------------
`define MRG_HR_REQ_PM 16'h0000
`define MRG_HR_EXIT_PM 16'h0001
`define MRG_HR_LASER 16'h019a
`define MRG_HR_SETUP 16'h01f5

// ----------------------------------------------------------------------
// Data values and exception codes
// ----------------------------------------------------------------------
`define MRG_WO_VALUE 16'hffff
`define MRG_EXC_ILL_FUNC 8'h01
`define MRG_EXC_ILL_ADDR 8'h02
`define MRG_EXC_ILL_VALUE 8'h03
`define MRG_EXC_NO_CONN 8'h04
`define MRG_EXC_NO_PM 8'h01
`define MRG_EXC_BUSY 8'h06

// ----------------------------------------------------------------------
// Interface numbering and reset values
// ----------------------------------------------------------------------
`define MRG_WEB_IF 0
`define MRG_RST_WORD 16'h0000
`define MRG_RST_CODE 8'h00
`define MRG_RST_DATA 32'h0000_0000

`endif

// ==== rtl/mrg_pkg.sv ====
// Types shared by the register access gate.
// Assumes nothing of its surroundings.
package mrg_pkg;

  // Sequencer states of the gate.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_USE = 3'b010,
    ST_HI = 3'b011,
    ST_WLO = 3'b100,
    ST_WHI = 3'b101,
    ST_COMMIT = 3'b110
  } mrg_state_e;

  // Independent address tables behind the gate.
  typedef enum logic [1:0] {
    MRG_TBL_DI = 2'b00,
    MRG_TBL_IR = 2'b01,
    MRG_TBL_HR = 2'b10
  } mrg_table_e;

endpackage

// ==== rtl/mrg_conn_slot.sv ====
// One client connection slot of one protocol interface.
// Assumes open and close requests are one-cycle pulses on clk_sys.
`timescale 1ns/1ns

module mrg_conn_slot (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic open_req,
  input wire logic close_req,
  output logic active,
  output logic refused
);

  // ----------------------------------------------------------------------
  // Slot state
  // ----------------------------------------------------------------------
  logic active_q; // A client holds this slot.
  logic refused_q; // A second client was turned away.

  // A second open while the slot is taken is refused, never queued.
  // An open that meets a close takes the freed slot instead of being lost.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_q <= 1'b0;
    end else if (open_req) begin
      active_q <= 1'b1; // R1
    end else if (close_req) begin
      active_q <= 1'b0;
    end
  end

  // The refusal is a one-cycle pulse so the link layer can drop the client.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= open_req && active_q && !close_req; // R1
    end
  end

  assign active = active_q;
  assign refused = refused_q;

endmodule

// ==== sim/mrg_backend_model.sv ====
// Behavioural model of the sensor tables behind the register access gate.
// Assumes lookups are answered on the cycle after be_rd, as the gate needs.
`timescale 1ns/1ns
`include "mrg_defines.svh"

module mrg_backend_model import mrg_pkg::*; (
  input wire logic clk_sys,
  input wire logic be_rd,
  input wire mrg_table_e be_table,
  input wire logic [15:0] be_addr,
  input wire logic be_wr,
  input wire logic [31:0] be_wdata,
  output logic [1:0] be_words,
  output logic be_first,
  output logic be_wo,
  output logic [31:0] be_rdata
);
  // ----------------------------------------------------------------------
  // Table storage
  // ----------------------------------------------------------------------
  logic [15:0] laser_q; // Laser state word.
  logic [31:0] wide_q; // Two-word item at address 4.

  initial begin
    laser_q = 16'h0000;
    wide_q = 32'h1234_5678;
    be_words = 2'h1;
    be_first = 1'b1;
    be_wo = 1'b0;
    be_rdata = 32'h0000_0000;
  end

  // Answers hold only for the cycle after a lookup; at other times they
  // toggle, so a gate that samples late cannot pass by luck.
  always @(posedge clk_sys) begin
    if (be_wr && be_addr == `MRG_HR_LASER) laser_q <= be_wdata[15:0];
    if (be_wr && be_addr == 16'h0004) wide_q <= be_wdata;
    if (be_rd) begin
      be_words <= (be_addr == 16'h0004) ? 2'h2 : 2'h1;
      be_first <= (be_addr != 16'h0005);
      be_wo <= (be_table == MRG_TBL_HR) && (be_addr < 16'h0002);
      if (be_addr == 16'h0004 || be_addr == 16'h0005) begin
        be_rdata <= wide_q;
      end else if (be_table == MRG_TBL_HR && be_addr == `MRG_HR_LASER) begin
        be_rdata <= {16'h0000, laser_q};
      end else begin
        be_rdata <= {16'h0000, be_addr ^ {be_table, 14'h0000}};
      end
    end else begin
      be_words <= ~be_words;
      be_first <= ~be_first;
      be_wo <= ~be_wo;
      be_rdata <= ~be_rdata;
    end
  end
endmodule

// ==== sim/tb_mrg_gate.sv ====
// Self-checking testbench of the register access gate; tasks act as clients.
// Assumes the backend model answers the table lookups.
`timescale 1ns/1ns
`include "mrg_defines.svh"

module tb_mrg_gate import mrg_pkg::*;;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] conn_open = 3'h0;
  logic [2:0] conn_close = 3'h0;
  logic [2:0] conn_active, conn_refused;
  logic req_valid = 1'b0;
  logic [1:0] req_if = 2'h0;
  logic [7:0] req_fc = 8'h00;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_count = 16'h0000;
  logic wdat_valid = 1'b0;
  logic [15:0] wdat_data = 16'h0000;
  logic req_ready, wdat_ready, rsp_valid, rsp_last, rsp_exc, be_rd, be_wr;
  logic [7:0] rsp_code, rcode;
  logic [15:0] rsp_data, be_addr;
  mrg_table_e be_table;
  logic [1:0] be_words, pm_owner;
  logic be_first, be_wo, pm_held, rexc;
  logic [31:0] be_rdata, be_wdata;
  logic [15:0] rq[$], wq[$]; // Received words and words still to write.
  int fails = 0;
  int total_checks = 0;

  initial forever #4 clk_sys = ~clk_sys;

  mrg_gate #(.N_IF(3), .IFW(2)) mrg_gate_inst (.clk_sys, .reset, .conn_open,
    .conn_close, .conn_active, .conn_refused, .req_valid, .req_ready,
    .req_if, .req_fc, .req_addr, .req_count, .wdat_valid, .wdat_ready,
    .wdat_data, .rsp_valid, .rsp_last, .rsp_exc, .rsp_code, .rsp_data,
    .be_rd, .be_table, .be_addr, .be_words, .be_first, .be_wo, .be_rdata,
    .be_wr, .be_wdata, .pm_held, .pm_owner);

  mrg_backend_model mrg_backend_model_inst (.clk_sys, .be_rd, .be_table,
    .be_addr, .be_wr, .be_wdata, .be_words, .be_first, .be_wo, .be_rdata);

  // ----------------------------------------------------------------------
  // Comparison and run control
  // ----------------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // An exception answer carries the flag and the given code.
  task automatic chk_exc(input logic [7:0] code);
    chk_bit(rexc, 1'b1);
    chk_word({8'h00, rcode}, {8'h00, code});
  endtask

  // Opens a slot; the answer is registered, so it shows after one edge.
  task automatic open_if(input int i, input logic refused);
    @(posedge clk_sys);
    #1;
    conn_open[i] = 1'b1;
    @(posedge clk_sys);
    #1;
    conn_open[i] = 1'b0;
    chk_bit(conn_active[i], 1'b1);
    chk_bit(conn_refused[i], refused);
  endtask

  // One whole request: handshakes are judged at the falling edge, where
  // the values the next rising edge samples are settled, and the drives
  // change just after the rising edge. Unused write words are dropped.
  task automatic xfer(input logic [1:0] ifn, input logic [7:0] fc,
    input logic [15:0] addr, input logic [15:0] cnt);
    int n;
    logic done, tk, wt;
    @(posedge clk_sys);
    #1;
    rq.delete();
    rexc = 1'b0;
    rcode = 8'h00;
    done = 1'b0;
    n = 0;
    req_if = ifn;
    req_fc = fc;
    req_addr = addr;
    req_count = cnt;
    req_valid = 1'b1;
    wdat_valid = (wq.size() != 0);
    if (wq.size() != 0) wdat_data = wq[0];
    while (!done && n < 60) begin
      @(negedge clk_sys);
      tk = req_valid && req_ready;
      wt = wdat_valid && wdat_ready;
      if (rsp_valid) begin
        rq.push_back(rsp_data);
        rexc = rsp_exc;
        rcode = rsp_code;
        done = rsp_last;
      end
      @(posedge clk_sys);
      #1;
      if (tk) req_valid = 1'b0;
      if (wt) void'(wq.pop_front());
      wdat_valid = !done && (wq.size() != 0);
      if (wq.size() != 0) wdat_data = wq[0];
      n++;
    end
    wq.delete();
    if (!done) begin
      fails++;
      $display("[ERR] %0t no final answer", $time);
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_conn();
    open_if(1, 1'b0);
    open_if(0, 1'b0);
    open_if(0, 1'b1);
  endtask

  // Reads with no mode held; address 3 differs in each table.
  task automatic sc_reads();
    xfer(2'h1, `MRG_FC_RD_IR, 16'h0004, 16'h0002);
    chk_word(rq[0], 16'h5678);
    chk_word(rq[1], 16'h1234);
    chk_bit(rexc, 1'b0);
    xfer(2'h1, `MRG_FC_RD_DI, 16'h0003, 16'h0001);
    chk_word(rq[0], 16'h0003);
    xfer(2'h1, `MRG_FC_RD_IR, 16'h0003, 16'h0001);
    chk_word(rq[0], 16'h4003);
    xfer(2'h1, `MRG_FC_RD_HR, 16'h0003, 16'h0001);
    chk_word(rq[0], 16'h8003);
  endtask

  // Refusals: write without mode, unknown code, split item, no slot.
  task automatic sc_refuse();
    wq = '{16'h0001};
    xfer(2'h1, `MRG_FC_WR_ONE, `MRG_HR_LASER, 16'h0001);
    chk_exc(`MRG_EXC_NO_PM);
    xfer(2'h1, `MRG_FC_RD_HR, `MRG_HR_LASER, 16'h0001);
    chk_word(rq[0], 16'h0000);
    xfer(2'h1, 8'h05, 16'h0000, 16'h0001);
    chk_exc(`MRG_EXC_ILL_FUNC);
    xfer(2'h1, `MRG_FC_RD_IR, 16'h0005, 16'h0001);
    chk_exc(`MRG_EXC_ILL_ADDR);
    xfer(2'h2, `MRG_FC_RD_IR, 16'h0003, 16'h0001);
    chk_exc(`MRG_EXC_NO_CONN);
  endtask

  // Mode taken by interface 1, refused to the web path, then left.
  task automatic sc_mode();
    wq = '{16'h00a5};
    xfer(2'h1, `MRG_FC_WR_ONE, `MRG_HR_REQ_PM, 16'h0001);
    chk_bit(rexc, 1'b0);
    chk_bit(pm_held, 1'b1);
    chk_word({14'h0000, pm_owner}, 16'h0001);
    wq = '{16'h00a5};
    xfer(2'h0, `MRG_FC_WR_ONE, `MRG_HR_REQ_PM, 16'h0001);
    chk_exc(`MRG_EXC_BUSY);
    wq = '{16'h0001};
    xfer(2'h1, `MRG_FC_WR_MANY, `MRG_HR_LASER, 16'h0001);
    chk_bit(rexc, 1'b0);
    xfer(2'h1, `MRG_FC_RD_HR, `MRG_HR_LASER, 16'h0001);
    chk_word(rq[0], 16'h0001);
    wq = '{16'h0002};
    xfer(2'h1, `MRG_FC_WR_ONE, 16'h0007, 16'h0001);
    chk_exc(`MRG_EXC_ILL_ADDR);
    xfer(2'h1, `MRG_FC_RD_HR, `MRG_HR_REQ_PM, 16'h0001);
    chk_word(rq[0], `MRG_WO_VALUE);
    wq = '{16'h0003};
    xfer(2'h1, `MRG_FC_WR_ONE, `MRG_HR_EXIT_PM, 16'h0001);
    chk_bit(pm_held, 1'b0);
  endtask

  // Web path writes a two-word item whole; half of it is refused.
  task automatic sc_web();
    wq = '{16'h0001};
    xfer(2'h0, `MRG_FC_WR_ONE, `MRG_HR_REQ_PM, 16'h0001);
    chk_bit(rexc, 1'b0);
    wq = '{16'h0bad};
    xfer(2'h0, `MRG_FC_WR_MANY, 16'h0004, 16'h0001);
    chk_exc(`MRG_EXC_ILL_ADDR);
    wq = '{16'hbeef, 16'hcafe};
    xfer(2'h0, `MRG_FC_WR_MANY, 16'h0004, 16'h0002);
    xfer(2'h0, `MRG_FC_RD_HR, 16'h0004, 16'h0002);
    chk_word(rq[0], 16'hbeef);
    chk_word(rq[1], 16'hcafe);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    sc_conn();
    sc_reads();
    sc_refuse();
    sc_mode();
    sc_web();
    complete_run();
  end
endmodule
